// file: hw/svq_engine.v
`timescale 1ns/100ps
`include "svq_consts.vh"
module svq_engine #(
  parameter NP  = 8,
  parameter PW  = 3,
  parameter NV  = 16,
  parameter VIW = 4
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst,
  input  wire              ce,
  // Register port
  input  wire [7:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_we,
  input  wire              reg_re,
  output wire [31:0]       reg_rdata,
  // Ingress frame descriptor
  input  wire              in_vld,
  input  wire [PW-1:0]     in_port,
  input  wire              in_tagged,
  input  wire [11:0]       in_vid,
  input  wire [2:0]        in_initial_frame_priority,
  input  wire [1:0]        in_initial_queue_priority,
  // Forwarding decision
  output wire              out_vld,
  output wire              out_accept,
  output wire              out_keep,
  output wire [NP-1:0]     out_egress,
  output wire [NP-1:0]     out_tagged,
  output wire [11:0]       out_vid,
  output wire [2:0]        out_tag_pri,
  output wire [1:0]        out_final_queue_priority,
  output wire [1:0]        out_addr_domain,
  // Egress queue scheduler
  input  wire [NP*4-1:0]   q_nonempty,
  input  wire [NP-1:0]     tx_ready,
  output reg  [NP-1:0]     grant_vld,
  output reg  [NP*2-1:0]   grant_q,
  // Channel speed sharing
  input  wire [15:0]       avail_speed,
  output wire [15:0]       first_traffic_channel_rate,
  output wire [15:0]       second_traffic_channel_rate
);

  // ****************************************
  // Functions
  // ****************************************
  function [VIW:0] svq_find;
    input [NV*12-1:0] vids;
    input [NV-1:0]    val;
    input [11:0]      v;
    integer i;
    begin
      svq_find = {(VIW+1){1'b0}};
      for (i = NV-1; i >= 0; i = i - 1) begin
        if (val[i] && vids[i*12 +: 12] == v) begin
          svq_find = {1'b1, i[VIW-1:0]};
        end
      end
    end
  endfunction

  // Zero limit means auto: take what is left
  function [15:0] svq_cap;
    input [15:0] lim;
    input [15:0] cap;
    begin
      svq_cap = (lim == 16'h0000 || lim > cap) ? cap : lim;
    end
  endfunction

  // Returns {valid, reload, queue}
  function [3:0] svq_pick;
    input [3:0]  ne;
    input [15:0] cr;
    input [1:0]  md;
    integer i;
    integer ns;
    reg     f;
    begin
      svq_pick = 4'h0;
      f = 1'b0;
      case (md)
        `SVQ_Q_WEIGHT: ns = 0;
        `SVQ_Q_TOP1:   ns = 1;
        `SVQ_Q_TOP2:   ns = 2;
        default:       ns = 4;
      endcase
      for (i = 3; i >= 0; i = i - 1) begin
        if (!f && ne[i] && i >= 4 - ns) begin
          f = 1'b1;
          svq_pick = {2'b10, i[1:0]};
        end
      end
      for (i = 3; i >= 0; i = i - 1) begin
        if (!f && ne[i] && cr[i*4 +: 4] != 4'h0) begin
          f = 1'b1;
          svq_pick = {2'b10, i[1:0]};
        end
      end
      // All waiting queues spent: start a fresh round
      for (i = 3; i >= 0; i = i - 1) begin
        if (!f && ne[i]) begin
          f = 1'b1;
          svq_pick = {2'b11, i[1:0]};
        end
      end
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [NV-1:0]   e_val_q;
  reg [11:0]     e_vid_q  [0:NV-1];
  reg [1:0]      e_grp_q  [0:NV-1];
  reg            e_oen_q  [0:NV-1];
  reg [1:0]      e_opr_q  [0:NV-1];
  reg [2*NP-1:0] e_mem_q  [0:NV-1];
  reg [1:0]      p_mode_q [0:NP-1];
  reg [1:0]      p_grp_q  [0:NP-1];
  reg [2:0]      p_pri_q  [0:NP-1];
  reg            p_ovr_q  [0:NP-1];
  reg [1:0]      p_qm_q   [0:NP-1];
  reg [15:0]     cr_q     [0:NP-1];
  reg [15:0]     lim_a_q;
  reg [15:0]     lim_b_q;
  reg [15:0]     rate_a_q;
  reg [15:0]     rate_b_q;
  reg [11:0]     stg_vid_q;
  reg [1:0]      stg_grp_q;
  reg            stg_oen_q;
  reg [1:0]      stg_opr_q;
  reg [2*NP-1:0] stg_mem_q;
  reg            cmd_ok_q;
  reg            cmd_err_q;
  reg [31:0]     rdata_q;
  reg            o_vld_q;
  reg            o_acc_q;
  reg            o_keep_q;
  reg [NP-1:0]   o_eg_q;
  reg [NP-1:0]   o_tg_q;
  reg [11:0]     o_vid_q;
  reg [2:0]      o_pri_q;
  reg [1:0]      o_qp_q;
  reg [1:0]      o_dom_q;

  // ****************************************
  // Table views
  // ****************************************
  reg [NV*12-1:0] vid_flat;
  reg [11:0]      pvid_c [0:NP-1];
  // Own loop indices for each process so no two processes share a driver
  integer         a;
  integer         b;
  integer         ta;
  integer         tb;
  integer         ib;
  integer         sb;
  integer         ca;
  integer         cb;

  always @* begin
    for (ta = 0; ta < NV; ta = ta + 1) begin
      vid_flat[ta*12 +: 12] = e_vid_q[ta];
    end
    for (tb = 0; tb < NP; tb = tb + 1) begin
      pvid_c[tb] = `SVQ_VID_INT;
      for (ta = NV-1; ta >= 0; ta = ta - 1) begin
        if (e_val_q[ta] && e_mem_q[ta][2*tb +: 2] == `SVQ_V_UNTAG) begin
          pvid_c[tb] = e_vid_q[ta];
        end
      end
    end
  end

  // ****************************************
  // Ingress classification
  // ****************************************
  reg [11:0]    i_vid;
  reg [VIW:0]   i_lk;
  reg [VIW-1:0] i_ix;
  reg           i_hit;
  reg           i_mem;
  reg [1:0]     i_md;
  reg [NP-1:0]  i_same;
  reg [NP-1:0]  i_memb;
  reg [NP-1:0]  i_tagm;
  reg           i_acc;
  reg           i_keep;
  reg [NP-1:0]  i_eg;
  reg [NP-1:0]  i_tg;
  reg [1:0]     i_qp;
  reg [2:0]     i_fp;

  always @* begin
    i_vid = in_tagged ? in_vid : pvid_c[in_port];
    i_lk  = svq_find(vid_flat, e_val_q, i_vid);
    i_ix  = i_lk[VIW-1:0];
    // Entry counts only inside its own group
    i_hit = i_lk[VIW] && e_grp_q[i_ix] == p_grp_q[in_port];
    i_mem = e_mem_q[i_ix][2*in_port +: 2] != `SVQ_V_DENY;
    for (ib = 0; ib < NP; ib = ib + 1) begin
      i_same[ib] = p_grp_q[ib] == p_grp_q[in_port] && ib != in_port;
      i_memb[ib] = i_hit && e_mem_q[i_ix][2*ib +: 2] != `SVQ_V_DENY;
      i_tagm[ib] = i_hit && e_mem_q[i_ix][2*ib +: 2] == `SVQ_V_TAG;
    end
    i_md = p_mode_q[in_port];
    if (i_md == `SVQ_M_HYBRID) begin
      i_md = i_hit ? `SVQ_M_TRUNK : `SVQ_M_BASIC;
    end
    i_acc  = 1'b0;
    i_keep = 1'b0;
    i_eg   = {NP{1'b0}};
    i_tg   = {NP{1'b0}};
    case (i_md)
      `SVQ_M_BASIC: begin
        i_acc  = 1'b1;
        i_keep = 1'b1;
        i_eg   = i_same;
      end
      `SVQ_M_ACCESS: begin
        i_acc = !in_tagged && i_hit;
        i_eg  = i_memb & i_same;
      end
      `SVQ_M_TRUNK: begin
        i_acc = i_hit && i_mem
              && !(!in_tagged && pvid_c[in_port] == `SVQ_VID_INT);
        i_eg  = i_memb & i_same;
        i_tg  = i_tagm & i_same;
      end
      default: begin
        i_acc = 1'b0;
      end
    endcase
    if (!i_acc) begin
      i_eg = {NP{1'b0}};
      i_tg = {NP{1'b0}};
    end
    i_qp = in_initial_queue_priority;
    if (p_ovr_q[in_port] && i_hit && e_oen_q[i_ix]) begin
      i_qp = e_opr_q[i_ix];
    end
    // Untagged frames carry the port priority
    i_fp = in_tagged ? in_initial_frame_priority : p_pri_q[in_port];
  end

  // ****************************************
  // Queue scheduler
  // ****************************************
  reg [3:0]  pk_c [0:NP-1];
  reg [15:0] cr_d [0:NP-1];

  always @* begin
    for (sb = 0; sb < NP; sb = sb + 1) begin
      pk_c[sb] = svq_pick(q_nonempty[4*sb +: 4], cr_q[sb], p_qm_q[sb]);
      grant_vld[sb] = pk_c[sb][3] && tx_ready[sb];
      grant_q[2*sb +: 2] = pk_c[sb][1:0];
      cr_d[sb] = pk_c[sb][2] ? `SVQ_WRR_LOAD : cr_q[sb];
      if (cr_d[sb][4*pk_c[sb][1:0] +: 4] != 4'h0) begin
        cr_d[sb][4*pk_c[sb][1:0] +: 4] = cr_d[sb][4*pk_c[sb][1:0] +: 4] - 4'h1;
      end
    end
  end

  // ****************************************
  // Table command checks
  // ****************************************
  reg [VIW:0]   c_lk;
  reg [VIW:0]   c_free;
  reg           c_busy;
  reg [VIW-1:0] c_slot;

  always @* begin
    c_lk   = svq_find(vid_flat, e_val_q, stg_vid_q);
    c_free = {(VIW+1){1'b0}};
    for (ca = NV-1; ca >= 0; ca = ca - 1) begin
      if (!e_val_q[ca]) begin
        c_free = {1'b1, ca[VIW-1:0]};
      end
    end
    c_busy = 1'b0;
    for (cb = 0; cb < NP; cb = cb + 1) begin
      if (e_mem_q[c_lk[VIW-1:0]][2*cb +: 2] == `SVQ_V_UNTAG
          && p_mode_q[cb] == `SVQ_M_ACCESS) begin
        c_busy = 1'b1;
      end
    end
    c_slot = c_lk[VIW] ? c_lk[VIW-1:0] : c_free[VIW-1:0];
  end

  // ****************************************
  // Register port decode
  // ****************************************
  wire         w_port = (reg_addr & `SVQ_A_WIN) == `SVQ_A_PORT;
  wire         w_pvid = (reg_addr & `SVQ_A_WIN) == `SVQ_A_PVID;
  wire [4:0]   w_ix   = {2'b00, reg_addr[4:2]};
  wire [PW-1:0] w_p   = w_ix[PW-1:0];
  wire         w_inp  = w_ix < NP;
  wire [1:0]   w_mode = reg_wdata[`SVQ_F_PMODE +: 2];

  // ****************************************
  // Clocked state
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      e_val_q   <= {NV{1'b0}};
      lim_a_q   <= 16'h0000;
      lim_b_q   <= 16'h0000;
      rate_a_q  <= 16'h0000;
      rate_b_q  <= 16'h0000;
      stg_vid_q <= 12'h000;
      stg_grp_q <= `SVQ_GRP_RST;
      stg_oen_q <= 1'b0;
      stg_opr_q <= 2'h0;
      stg_mem_q <= {2*NP{1'b0}};
      cmd_ok_q  <= 1'b0;
      cmd_err_q <= 1'b0;
      rdata_q   <= 32'h00000000;
      o_vld_q   <= 1'b0;
      o_acc_q   <= 1'b0;
      o_keep_q  <= 1'b0;
      o_eg_q    <= {NP{1'b0}};
      o_tg_q    <= {NP{1'b0}};
      o_vid_q   <= 12'h000;
      o_pri_q   <= 3'h0;
      o_qp_q    <= 2'h0;
      o_dom_q   <= 2'h0;
      for (a = 0; a < NV; a = a + 1) begin
        e_vid_q[a] <= 12'h000;
        e_grp_q[a] <= `SVQ_GRP_RST;
        e_oen_q[a] <= 1'b0;
        e_opr_q[a] <= 2'h0;
        e_mem_q[a] <= {2*NP{1'b0}};
      end
      for (b = 0; b < NP; b = b + 1) begin
        p_mode_q[b] <= `SVQ_M_BASIC;
        p_grp_q[b]  <= `SVQ_GRP_RST;
        p_pri_q[b]  <= `SVQ_PRI_RST;
        p_ovr_q[b]  <= 1'b0;
        p_qm_q[b]   <= `SVQ_Q_WEIGHT;
        cr_q[b]     <= `SVQ_WRR_LOAD;
      end
    end else if (ce) begin
      // Channel sharing
      rate_a_q <= svq_cap(lim_a_q, avail_speed);
      rate_b_q <= svq_cap(lim_b_q, avail_speed - svq_cap(lim_a_q, avail_speed));
      // Scheduler credits
      for (b = 0; b < NP; b = b + 1) begin
        if (grant_vld[b]) begin
          cr_q[b] <= cr_d[b];
        end
      end
      // Decision output
      o_vld_q <= in_vld;
      if (in_vld) begin
        o_acc_q  <= i_acc;
        o_keep_q <= i_keep;
        o_eg_q   <= i_eg;
        o_tg_q   <= i_tg;
        o_vid_q  <= i_vid;
        o_pri_q  <= i_fp;
        o_qp_q   <= i_qp;
        o_dom_q  <= p_grp_q[in_port];
      end
      // Register writes
      if (reg_we) begin
        case (reg_addr)
          `SVQ_A_SPEED: begin
            lim_a_q <= reg_wdata[`SVQ_F_LIMA +: 16];
            lim_b_q <= reg_wdata[`SVQ_F_LIMB +: 16];
          end
          `SVQ_A_VSTAGE: begin
            stg_vid_q <= reg_wdata[`SVQ_F_VID +: 12];
            stg_grp_q <= reg_wdata[`SVQ_F_VGRP +: 2];
            stg_oen_q <= reg_wdata[`SVQ_F_VOEN];
            stg_opr_q <= reg_wdata[`SVQ_F_VOPR +: 2];
          end
          `SVQ_A_VMEMB: begin
            stg_mem_q <= reg_wdata[2*NP-1:0];
          end
          `SVQ_A_VCMD: begin
            if (reg_wdata[`SVQ_F_ADD]) begin
              if (stg_vid_q == `SVQ_VID_INT || stg_vid_q == 12'h000
                  || (c_lk[VIW] && e_grp_q[c_slot] != stg_grp_q)
                  || !(c_lk[VIW] || c_free[VIW])) begin
                cmd_ok_q  <= 1'b0;
                cmd_err_q <= 1'b1;
              end else begin
                e_val_q[c_slot] <= 1'b1;
                e_vid_q[c_slot] <= stg_vid_q;
                e_grp_q[c_slot] <= stg_grp_q;
                e_oen_q[c_slot] <= stg_oen_q;
                e_opr_q[c_slot] <= stg_opr_q;
                e_mem_q[c_slot] <= stg_mem_q;
                cmd_ok_q  <= 1'b1;
                cmd_err_q <= 1'b0;
              end
            end else if (reg_wdata[`SVQ_F_DEL]) begin
              if (!c_lk[VIW] || c_busy) begin
                cmd_ok_q  <= 1'b0;
                cmd_err_q <= 1'b1;
              end else begin
                e_val_q[c_lk[VIW-1:0]] <= 1'b0;
                cmd_ok_q  <= 1'b1;
                cmd_err_q <= 1'b0;
              end
            end
          end
          default: begin
            if (w_port && w_inp) begin
              // Access on the internal VLAN keeps the old mode
              if (!(w_mode == `SVQ_M_ACCESS && pvid_c[w_p] == `SVQ_VID_INT)) begin
                p_mode_q[w_p] <= w_mode;
              end
              p_grp_q[w_p] <= reg_wdata[`SVQ_F_PGRP +: 2];
              p_pri_q[w_p] <= reg_wdata[`SVQ_F_PPRI +: 3];
              p_ovr_q[w_p] <= reg_wdata[`SVQ_F_POVR];
              p_qm_q[w_p]  <= reg_wdata[`SVQ_F_PQM +: 2];
            end
          end
        endcase
      end
      // Register reads, data one cycle later
      rdata_q <= 32'h00000000;
      if (reg_re) begin
        case (reg_addr)
          `SVQ_A_SPEED:  rdata_q <= {lim_b_q, lim_a_q};
          `SVQ_A_RATES:  rdata_q <= {rate_b_q, rate_a_q};
          `SVQ_A_VSTAGE: rdata_q <= {15'h0000, stg_opr_q, stg_oen_q, stg_grp_q, stg_vid_q};
          `SVQ_A_VMEMB:  rdata_q <= {{(32-2*NP){1'b0}}, stg_mem_q};
          `SVQ_A_VCMD:   rdata_q <= {30'h00000000, cmd_err_q, cmd_ok_q};
          default: begin
            if (w_port && w_inp) begin
              rdata_q <= {22'h000000, p_qm_q[w_p], p_ovr_q[w_p], p_pri_q[w_p],
                          p_grp_q[w_p], p_mode_q[w_p]};
            end else if (w_pvid && w_inp) begin
              rdata_q <= {20'h00000, pvid_c[w_p]};
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata                   = rdata_q;
  assign out_vld                     = o_vld_q;
  assign out_accept                  = o_acc_q;
  assign out_keep                    = o_keep_q;
  assign out_egress                  = o_eg_q;
  assign out_tagged                  = o_tg_q;
  assign out_vid                     = o_vid_q;
  assign out_tag_pri                 = o_pri_q;
  assign out_final_queue_priority    = o_qp_q;
  assign out_addr_domain             = o_dom_q;
  assign first_traffic_channel_rate  = rate_a_q;
  assign second_traffic_channel_rate = rate_b_q;

endmodule

// file: shared/svq_consts.vh
`ifndef SVQ_CONSTS_VH
`define SVQ_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define SVQ_A_SPEED   8'h00
`define SVQ_A_RATES   8'h04
`define SVQ_A_VSTAGE  8'h08
`define SVQ_A_VMEMB   8'h0c
`define SVQ_A_VCMD    8'h10
`define SVQ_A_PORT    8'h20
`define SVQ_A_PVID    8'h40
`define SVQ_A_WIN     8'he0

// ****************************************
// Field positions
// ****************************************
`define SVQ_F_LIMA    0
`define SVQ_F_LIMB    16
`define SVQ_F_VID     0
`define SVQ_F_VGRP    12
`define SVQ_F_VOEN    14
`define SVQ_F_VOPR    15
`define SVQ_F_ADD     0
`define SVQ_F_DEL     1
`define SVQ_F_PMODE   0
`define SVQ_F_PGRP    2
`define SVQ_F_PPRI    4
`define SVQ_F_POVR    7
`define SVQ_F_PQM     8

// ****************************************
// Encodings
// ****************************************
`define SVQ_M_BASIC   2'h0
`define SVQ_M_ACCESS  2'h1
`define SVQ_M_TRUNK   2'h2
`define SVQ_M_HYBRID  2'h3
`define SVQ_V_DENY    2'h0
`define SVQ_V_UNTAG   2'h1
`define SVQ_V_TAG     2'h2
`define SVQ_Q_WEIGHT  2'h0
`define SVQ_Q_TOP1    2'h1
`define SVQ_Q_TOP2    2'h2
`define SVQ_Q_STRICT  2'h3

// ****************************************
// Reset values
// ****************************************
`define SVQ_VID_INT   12'h001
`define SVQ_PRI_RST   3'h0
`define SVQ_GRP_RST   2'h0
`define SVQ_WRR_LOAD  16'h8421

`endif

// file: tb/svq_engine_chk.sv
`timescale 1ns/100ps
// ********
// Checker
// ********
module svq_engine_chk #(
  parameter NP = 8,
  parameter PW = 3
) (
  // Clock and reset
  input logic              clk,
  input logic              rst,
  input logic              ce,
  // Register read
  input logic              reg_re,
  input logic [31:0]       reg_rdata,
  // Ingress and decision
  input logic              in_vld,
  input logic [PW-1:0]     in_port,
  input logic              in_tagged,
  input logic [2:0]        in_initial_frame_priority,
  input logic              out_vld,
  input logic              out_accept,
  input logic              out_keep,
  input logic [NP-1:0]     out_egress,
  input logic [2:0]        out_tag_pri,
  // Scheduler and rates
  input logic [NP*4-1:0]   q_nonempty,
  input logic [NP-1:0]     tx_ready,
  input logic [NP-1:0]     grant_vld,
  input logic [NP*2-1:0]   grant_q,
  input logic [15:0]       avail_speed,
  input logic [15:0]       first_traffic_channel_rate,
  input logic [15:0]       second_traffic_channel_rate
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_out_vld_lag: assert property (ce |=> out_vld == $past(in_vld))
    else $error("decision pulse not one cycle after request");
  a_reject_no_egress: assert property (!out_accept |-> out_egress == '0)
    else $error("rejected frame has egress ports");
  a_no_self_egress: assert property (out_vld |-> !out_egress[$past(in_port)])
    else $error("frame sent back to its ingress port");
  a_keep_accepts: assert property (out_keep |-> out_accept)
    else $error("transparent frame not accepted");
  a_tag_pri_kept: assert property (out_vld && out_accept && $past(in_tagged)
    |-> out_tag_pri == $past(in_initial_frame_priority))
    else $error("tag priority differs from frame priority");
  a_grant_ready: assert property ((grant_vld & ~tx_ready) == '0)
    else $error("grant to a port that is not ready");
  a_grant_nonempty: assert property (grant_vld[0] |-> q_nonempty[grant_q[1:0]])
    else $error("grant to an empty queue");
  a_no_stall: assert property (tx_ready[0] && q_nonempty[3:0] != 4'h0
    |-> grant_vld[0])
    else $error("scheduler idle with waiting frames");
  a_rate_share: assert property ({1'b0, first_traffic_channel_rate}
    + {1'b0, second_traffic_channel_rate} <= {1'b0, $past(avail_speed)})
    else $error("channel rates exceed available speed");
  a_rd_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");

  c_keep: cover property (out_vld && out_keep);
  c_trunk: cover property (out_vld && out_accept && !out_keep);
  c_low_q: cover property (grant_vld[0] && grant_q[1:0] == 2'h0);
endmodule

bind svq_engine svq_engine_chk #(.NP(NP), .PW(PW)) i_chk (
  .clk(clk), .rst(rst), .ce(ce), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .in_vld(in_vld), .in_port(in_port), .in_tagged(in_tagged),
  .in_initial_frame_priority(in_initial_frame_priority), .out_vld(out_vld),
  .out_accept(out_accept), .out_keep(out_keep), .out_egress(out_egress),
  .out_tag_pri(out_tag_pri), .q_nonempty(q_nonempty), .tx_ready(tx_ready),
  .grant_vld(grant_vld), .grant_q(grant_q), .avail_speed(avail_speed),
  .first_traffic_channel_rate(first_traffic_channel_rate),
  .second_traffic_channel_rate(second_traffic_channel_rate));

// file: tb/svq_port_model.sv
`timescale 1ns/100ps
// ********
// Egress port model
// ********
module svq_port_model #(
  parameter NP = 8
) (
  // Clock and reset
  input  logic            clk,
  input  logic            rst,
  // Bench control
  input  logic            load,
  input  logic [15:0]     load_cnt,
  // Scheduler side
  input  logic [NP-1:0]   grant_vld,
  input  logic [NP*2-1:0] grant_q,
  output logic [NP*4-1:0] q_nonempty,
  output logic [NP-1:0]   tx_ready
);
  logic [3:0] cnt_q [4];
  logic [1:0] stall_q;

  // Port 0 holds frames; others idle
  always_comb begin
    q_nonempty = '0;
    for (int q = 0; q < 4; q++)
      q_nonempty[q] = cnt_q[q] != 4'h0;
    tx_ready = '1;
    // Stall one cycle in four so refusals happen mid-sequence
    tx_ready[0] = stall_q != 2'h3;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '{default: 4'h0};
      stall_q <= 2'h0;
    end else begin
      stall_q <= stall_q + 2'h1;
      if (load) begin
        for (int q = 0; q < 4; q++)
          cnt_q[q] <= load_cnt[4*q +: 4];
      end else if (grant_vld[0] && tx_ready[0]) begin
        // No guard: a grant on an empty queue wraps and shows up
        cnt_q[grant_q[1:0]] <= cnt_q[grant_q[1:0]] - 4'h1;
      end
    end
  end
endmodule

// file: tb/tb_svq_engine.sv
`timescale 1ns/100ps
`include "svq_consts.vh"
module tb_svq_engine;
  typedef struct packed {
    logic [2:0] p; logic t; logic [11:0] v; logic [2:0] fp; logic [1:0] qp;
    logic a; logic k; logic [7:0] e; logic [7:0] tm; logic [1:0] q; logic [2:0] tp;
    logic [1:0] d;
  } svq_row_t;
  logic        clk = 1'b0, rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0;
  logic        in_vld = 1'b0, in_tagged = 1'b0, load = 1'b0, ce = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, q_nonempty;
  logic [2:0]  in_port = 3'h0, in_fp = 3'h0, out_tag_pri;
  logic [11:0] in_vid = 12'h000, out_vid;
  logic [1:0]  in_qp = 2'h0, out_q, out_dom;
  logic [15:0] avail = 16'h0, load_cnt = 16'h0, rate_a, rate_b, grant_q;
  logic [7:0]  out_egress, out_tagged, tx_ready, grant_vld;
  logic        out_vld, out_accept, out_keep;
  int          err_total = 0, total_checks = 0;
  svq_row_t    rows [9];

  always #25 clk = ~clk;

  svq_engine i_dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .in_vld(in_vld), .in_port(in_port), .in_tagged(in_tagged), .in_vid(in_vid),
    .in_initial_frame_priority(in_fp), .in_initial_queue_priority(in_qp),
    .out_vld(out_vld), .out_accept(out_accept), .out_keep(out_keep),
    .out_egress(out_egress), .out_tagged(out_tagged), .out_vid(out_vid),
    .out_tag_pri(out_tag_pri), .out_final_queue_priority(out_q),
    .out_addr_domain(out_dom), .q_nonempty(q_nonempty), .tx_ready(tx_ready),
    .grant_vld(grant_vld), .grant_q(grant_q), .avail_speed(avail),
    .first_traffic_channel_rate(rate_a), .second_traffic_channel_rate(rate_b));
  svq_port_model i_far (.clk(clk), .rst(rst), .load(load), .load_cnt(load_cnt),
    .grant_vld(grant_vld), .grant_q(grant_q), .q_nonempty(q_nonempty),
    .tx_ready(tx_ready));

  // ********
  // Tasks
  // ********
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  task send(input svq_row_t x);
    @(posedge clk);
    {in_port, in_tagged, in_vid, in_fp, in_qp} <= {x.p, x.t, x.v, x.fp, x.qp};
    in_vld <= 1'b1;
    @(posedge clk);
    in_vld <= 1'b0;
    @(negedge clk);
    chk(out_vld, 1'b1);
    chk({out_accept, out_keep, out_egress, out_dom}, {x.a, x.k, x.e, x.d});
    if (x.a)
      chk({out_q, out_tag_pri}, {x.q, x.tp});
    if (x.a && !x.k)
      chk(out_tagged, x.tm);
    if (x.a && x.t)
      chk(out_vid, x.v);
  endtask
  // Fresh reset each run so round robin allowance starts full
  task sched(input logic [1:0] m, input logic [15:0] ld, input int n, input logic [63:0] s);
    int k;
    do_reset;
    wr(`SVQ_A_PORT, {22'h0, m, 8'h00});
    @(posedge clk);
    load_cnt <= ld;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    k = 0;
    repeat (200) begin
      @(negedge clk);
      if (k < n && grant_vld[0] === 1'b1) begin
        chk(grant_q[1:0], s[63-4*k -: 4]);
        k++;
      end
    end
    chk(k, n);
    $display("schedule mode %0d done", m);
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    do_reset;
    rd(`SVQ_A_PORT + 8'h04, 32'h0);
    wr(`SVQ_A_PORT + 8'h04, 32'h21);
    rd(`SVQ_A_PORT + 8'h04, 32'h20);
    rd(`SVQ_A_PVID + 8'h04, 32'h1);
    wr(`SVQ_A_VSTAGE, 32'h1);
    wr(`SVQ_A_VCMD, 32'h1);
    rd(`SVQ_A_VCMD, 32'h2);
    wr(`SVQ_A_VSTAGE, 32'h1c005);
    wr(`SVQ_A_VMEMB, 32'h26);
    wr(`SVQ_A_VCMD, 32'h1);
    rd(`SVQ_A_VCMD, 32'h1);
    rd(`SVQ_A_PVID + 8'h04, 32'h5);
    rd(`SVQ_A_PVID, 32'h1);
    wr(`SVQ_A_VSTAGE, 32'h1005);
    wr(`SVQ_A_VCMD, 32'h1);
    rd(`SVQ_A_VCMD, 32'h2);
    wr(`SVQ_A_PORT, 32'h82);
    wr(`SVQ_A_PORT + 8'h04, 32'h21);
    rd(`SVQ_A_PORT + 8'h04, 32'h21);
    wr(`SVQ_A_PORT + 8'h08, 32'h3);
    wr(`SVQ_A_PORT + 8'h10, 32'h4);
    wr(`SVQ_A_PORT + 8'h14, 32'h4);
    wr(`SVQ_A_PORT + 8'h1c, 32'h70);
    rd(`SVQ_A_PORT + 8'h1c, 32'h70);
    rd(8'hfc, 32'h0);
    wr(`SVQ_A_VSTAGE, 32'h5);
    wr(`SVQ_A_VCMD, 32'h2);
    rd(`SVQ_A_VCMD, 32'h2);
    $display("register tests done");
    rows[0] = '{3'h0,1'h1,12'h005,3'h6,2'h1,1'h1,1'h0,8'h06,8'h04,2'h3,3'h6,2'h0};
    rows[1] = '{3'h0,1'h1,12'h009,3'h6,2'h1,1'h0,1'h0,8'h00,8'h00,2'h0,3'h0,2'h0};
    rows[2] = '{3'h0,1'h0,12'h000,3'h0,2'h1,1'h0,1'h0,8'h00,8'h00,2'h0,3'h0,2'h0};
    rows[3] = '{3'h1,1'h0,12'h000,3'h0,2'h2,1'h1,1'h0,8'h05,8'h00,2'h2,3'h2,2'h0};
    rows[4] = '{3'h1,1'h1,12'h005,3'h3,2'h2,1'h0,1'h0,8'h00,8'h00,2'h0,3'h0,2'h0};
    rows[5] = '{3'h2,1'h1,12'h005,3'h5,2'h1,1'h1,1'h0,8'h03,8'h01,2'h1,3'h5,2'h0};
    rows[6] = '{3'h2,1'h1,12'h009,3'h5,2'h1,1'h1,1'h1,8'hcb,8'h00,2'h1,3'h5,2'h0};
    rows[7] = '{3'h3,1'h1,12'h007,3'h4,2'h0,1'h1,1'h1,8'hc7,8'h00,2'h0,3'h4,2'h0};
    rows[8] = '{3'h4,1'h0,12'h000,3'h0,2'h2,1'h1,1'h1,8'h20,8'h00,2'h2,3'h0,2'h1};
    foreach (rows[i])
      send(rows[i]);
    $display("forwarding rows done");
    // Port 1 leaves access mode, so the entry may go
    wr(`SVQ_A_PORT + 8'h04, 32'h20);
    wr(`SVQ_A_VCMD, 32'h2);
    rd(`SVQ_A_VCMD, 32'h1);
    rd(`SVQ_A_PVID + 8'h04, 32'h1);
    $display("vlan removal done");
    @(posedge clk);
    avail <= 16'h006e;
    wr(`SVQ_A_SPEED, 32'h006e0032);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({rate_b, rate_a}, 32'h003c0032);
    rd(`SVQ_A_RATES, 32'h003c0032);
    @(posedge clk);
    avail <= 16'h0028;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({rate_b, rate_a}, 32'h00000028);
    // Enable low must freeze the rates
    @(posedge clk);
    ce <= 1'b0;
    avail <= 16'h006e;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({rate_b, rate_a}, 32'h00000028);
    @(posedge clk);
    ce <= 1'b1;
    $display("speed sharing done");
    do_reset;
    @(negedge clk);
    chk({out_vld, out_accept, out_keep, out_egress, out_tagged}, 32'h0);
    rd(`SVQ_A_SPEED, 32'h0);
    rd(`SVQ_A_PORT + 8'h1c, 32'h0);
    $display("reset test done");
    sched(`SVQ_Q_WEIGHT, 16'hffff, 15, 64'h3333333322221100);
    sched(`SVQ_Q_WEIGHT, 16'h0505, 10, 64'h2222020000000000);
    sched(`SVQ_Q_STRICT, 16'h2222, 8, 64'h3322110000000000);
    sched(`SVQ_Q_TOP1, 16'h2530, 6, 64'h3322220000000000);
    sched(`SVQ_Q_TOP2, 16'h1233, 6, 64'h3221100000000000);
    tally_and_finish;
  end

  // Whole run is about 1200 cycles
  initial begin
    #1000000;
    err_total++;
    tally_and_finish;
  end
endmodule
